// ### core/elf_pkg.sv
// constants for the encoder latch and fault status block
package elf_pkg;
	// ------------------------------------------------------------
	// clock and timing
	// ------------------------------------------------------------
	localparam int CLK_MHZ        = 250;                       // core clock rate
	localparam int FLASH_HALF_MS  = 250;                       // error led half period
	localparam int FLASH_HALF_CYC = FLASH_HALF_MS * CLK_MHZ * 1000;
	// ------------------------------------------------------------
	// pin vector positions
	// ------------------------------------------------------------
	localparam int PIN_CNT  = 6;
	localparam int PIN_A    = 0;                               // encoder track a
	localparam int PIN_B    = 1;                               // encoder track b
	localparam int PIN_ZERO = 2;                               // encoder zero mark
	localparam int PIN_GATE = 3;                               // latch/gate input
	localparam int PIN_IN1  = 4;                               // digital input one
	localparam int PIN_IN2  = 5;                               // digital input two
	// ------------------------------------------------------------
	// temperature thresholds in degrees celsius
	// ------------------------------------------------------------
	localparam logic [7:0] TEMP_WARN_SET = 8'h50;              // 80 C
	localparam logic [7:0] TEMP_WARN_CLR = 8'h3C;              // 60 C
	localparam logic [7:0] TEMP_SHUTDOWN = 8'h7D;              // 125 C
	// ------------------------------------------------------------
	// sizes and reset values
	// ------------------------------------------------------------
	localparam int PARAM_CNT  = 8;                             // motion parameter words
	localparam int PARAM_W    = 16;
	localparam int POS_W      = 32;
	localparam logic [6:0] USTEP_RST = 7'h01;                  // full step after reset
	localparam logic [6:0] USTEP_MAX = 7'h40;                  // 64 steps per quarter
endpackage

// ### core/elf_encoder_latch_fault.sv
// encoder evaluation, position latch array and fault status logic
`timescale 1ns/1ns
// Overview of operation
// [RULE1] count every edge of both encoder tracks
// [RULE2] latch on zero, gate, input one, two
// [RULE3] one latch, or array up to count
// [RULE4] per-source arm bits, fixed priority order
// [RULE5] armed then clear request zeroes position at next latch
// [RULE6] capture position, then raise latch valid
// [RULE7] readout shows low word, acknowledges it
// [RULE8] upper word only on separate register port
// [RULE9] next toggle advances, ack toggle follows
// [RULE10] dropping enable discards all stored latches
// [RULE11] per-input polarity, one means normally closed
// [RULE12] zero motion parameter raises config error
// [RULE13] range error too, self clearing, no general
// [RULE14] warning at 80, clears below 60
// [RULE15] hardware faults cut power, set error
// [RULE16] reinitialise when control supply returns
// [RULE17] acknowledge clears error once cause gone
// [RULE18] housing temperature readable on port
// [RULE19] above 125 shutdown and flash led
// [RULE20] microsteps: power of two, 1 to 64
// [RULE21] disabled latching clears valid and readout
module elf_encoder_latch_fault
	import elf_pkg::*;
#(
	parameter int LATCH_DEPTH = 8,                             // latch array entries
	parameter int FLASH_CYC   = FLASH_HALF_CYC                 // led half period in cycles
)(
	input  wire logic                         clk,
	input  wire logic                         sys_rst,
	input  wire logic [PIN_CNT-1:0]           pins,
	input  wire logic                         arm_zero_mark_latch,
	input  wire logic                         arm_input_one_latch,
	input  wire logic                         arm_input_two_latch,
	input  wire logic                         arm_gate_rise_latch,
	input  wire logic                         arm_gate_fall_latch,
	input  wire logic                         latch_readout_request,
	input  wire logic                         next_latch_toggle,
	input  wire logic                         clear_position_request,
	input  wire logic                         latch_clears_position_enable,
	input  wire logic                         latch_array_enable,
	input  wire logic [7:0]                   latch_count_setting,
	input  wire logic                         input_one_polarity,
	input  wire logic                         input_two_polarity,
	input  wire logic [PARAM_CNT*PARAM_W-1:0] motion_params,
	input  wire logic                         bad_configuration,
	input  wire logic [6:0]                   microstep_resolution,
	input  wire logic [7:0]                   temp_sensor,
	input  wire logic                         undervoltage_det,
	input  wire logic                         open_load_a_det,
	input  wire logic                         open_load_b_det,
	input  wire logic                         overcurrent_a_det,
	input  wire logic                         overcurrent_b_det,
	input  wire logic                         control_supply_ok,
	input  wire logic                         error_acknowledge,
	output logic [POS_W-1:0]                  position,
	output logic [15:0]                       input_process_word,
	output logic [15:0]                       latch_upper_word,
	output logic                              latch_valid_flag,
	output logic                              latch_readout_ack,
	output logic                              next_latch_ack,
	output logic [6:0]                        microstep_setting,
	output logic [7:0]                        housing_temperature,
	output logic                              config_error_flag,
	output logic                              temp_warning_flag,
	output logic                              overtemp_flag,
	output logic                              undervoltage_flag,
	output logic                              open_load_a_flag,
	output logic                              open_load_b_flag,
	output logic                              overcurrent_a_flag,
	output logic                              overcurrent_b_flag,
	output logic                              control_supply_lost_flag,
	output logic                              general_error_flag,
	output logic                              motor_power_enable,
	output logic                              error_b_led,
	output logic                              reinit_pulse
);
	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	localparam int IDX_W = $clog2(LATCH_DEPTH + 1);
	localparam logic [IDX_W-1:0] DEPTH_N = IDX_W'(LATCH_DEPTH);

	// a resolution is legal only as a single set bit up to 64
	function automatic logic ustep_ok(input logic [6:0] v);
		ustep_ok = (v != 7'h00) && ((v & (v - 7'h01)) == 7'h00) && (v <= USTEP_MAX);
	endfunction

	// ------------------------------------------------------------
	// pin synchronisers: three stages, change when 2nd and 3rd agree
	// ------------------------------------------------------------
	logic [PIN_CNT-1:0] sync1, sync2, sync3, filt;           // sync chain and filtered level
	logic [PIN_CNT-1:0] next_filt;

	// filtered level only moves when the last two stages agree
	always_comb begin
		for (int i = 0; i < PIN_CNT; i++) begin
			next_filt[i] = (sync2[i] == sync3[i]) ? sync3[i] : filt[i];
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			sync1 <= '0;
			sync2 <= '0;
			sync3 <= '0;
			filt  <= '0;
		end else begin
			sync1 <= pins;
			sync2 <= sync1;
			sync3 <= sync2;
			filt  <= next_filt;
		end
	end

	// ------------------------------------------------------------
	// edge sources
	// ------------------------------------------------------------
	logic in1_lvl, in2_lvl, in1_old, in2_old;                // polarity corrected inputs
	logic zero_rise, gate_rise, gate_fall, in1_rise, in2_rise;
	logic latch_enable, latch_event;
	assign in1_lvl   = next_filt[PIN_IN1] ^ input_one_polarity;     // RULE11
	assign in2_lvl   = next_filt[PIN_IN2] ^ input_two_polarity;     // RULE11
	assign in1_old   = filt[PIN_IN1] ^ input_one_polarity;
	assign in2_old   = filt[PIN_IN2] ^ input_two_polarity;
	assign zero_rise = next_filt[PIN_ZERO] & ~filt[PIN_ZERO];       // RULE2
	assign gate_rise = next_filt[PIN_GATE] & ~filt[PIN_GATE];
	assign gate_fall = ~next_filt[PIN_GATE] & filt[PIN_GATE];
	assign in1_rise  = in1_lvl & ~in1_old;
	assign in2_rise  = in2_lvl & ~in2_old;
	assign latch_enable = arm_zero_mark_latch | arm_gate_rise_latch | arm_gate_fall_latch
		| arm_input_one_latch | arm_input_two_latch;

	// priority walk; simultaneous sources collapse into one capture
	always_comb begin
		if (arm_zero_mark_latch && zero_rise) begin             // RULE4
			latch_event = 1'b1;
		end else if (arm_gate_rise_latch && gate_rise) begin
			latch_event = 1'b1;
		end else if (arm_gate_fall_latch && gate_fall) begin
			latch_event = 1'b1;
		end else if (arm_input_one_latch && in1_rise) begin
			latch_event = 1'b1;
		end else begin
			latch_event = arm_input_two_latch & in2_rise;
		end
	end

	// ------------------------------------------------------------
	// quadrature position counter
	// ------------------------------------------------------------
	logic [POS_W-1:0] next_position;
	logic             clr_pending, next_clr_pending, clr_req_old;
	logic             a_chg, b_chg;
	assign a_chg = next_filt[PIN_A] ^ filt[PIN_A];
	assign b_chg = next_filt[PIN_B] ^ filt[PIN_B];

	// one step per track edge; a double change is a glitch and is dropped
	always_comb begin
		next_position    = position;
		next_clr_pending = clr_pending;
		if (a_chg ^ b_chg) begin                                // RULE1
			if (filt[PIN_A] ^ next_filt[PIN_B]) begin
				next_position = position + 32'h0000_0001;
			end else begin
				next_position = position - 32'h0000_0001;
			end
		end
		// clear request only counts after a source is armed
		if (latch_clears_position_enable && latch_enable && clear_position_request && !clr_req_old) begin
			next_clr_pending = 1'b1;                            // RULE5
		end
		if (!latch_enable || !latch_clears_position_enable) begin
			next_clr_pending = 1'b0;
		end else if (clr_pending && latch_event) begin
			next_position    = '0;                              // RULE5
			next_clr_pending = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			position    <= '0;
			clr_pending <= 1'b0;
			clr_req_old <= 1'b0;
		end else begin
			position    <= next_position;
			clr_pending <= next_clr_pending;
			clr_req_old <= clear_position_request;
		end
	end

	// ------------------------------------------------------------
	// latch array and readout
	// ------------------------------------------------------------
	logic [POS_W-1:0] store [LATCH_DEPTH];                   // captured positions
	logic [POS_W-1:0] next_store [LATCH_DEPTH];
	logic [IDX_W-1:0] fill, next_fill, rd_idx, next_rd_idx, target;
	logic             next_valid, next_ro_ack, next_nx_ack, nx_old;
	logic [15:0]      next_pword, next_upper;
	logic [POS_W-1:0] rd_word;

	// target entries: one by default, programmed count in array mode
	always_comb begin
		if (!latch_array_enable || latch_count_setting == 8'h00) begin
			target = IDX_W'(1);                                 // RULE3
		end else if ({24'h0, latch_count_setting} > LATCH_DEPTH) begin
			target = DEPTH_N;
		end else begin
			target = IDX_W'(latch_count_setting);
		end
	end
	assign rd_word = store[rd_idx[$clog2(LATCH_DEPTH)-1:0]];

	always_comb begin
		for (int i = 0; i < LATCH_DEPTH; i++) begin
			next_store[i] = store[i];
		end
		next_fill   = fill;
		next_rd_idx = rd_idx;
		next_valid  = latch_valid_flag;
		next_ro_ack = latch_readout_ack;
		next_nx_ack = next_latch_ack;
		next_pword  = input_process_word;
		next_upper  = latch_upper_word;
		// capture until the programmed number of entries is filled
		if (latch_event && fill < target) begin                 // RULE6
			next_store[fill[$clog2(LATCH_DEPTH)-1:0]] = position;
			next_fill = fill + IDX_W'(1);
			next_valid = (next_fill == target);                 // RULE6
		end
		// present the selected entry while readout is requested
		if (latch_readout_request && latch_valid_flag) begin
			next_ro_ack = 1'b1;                                 // RULE7
			next_pword  = rd_word[15:0];                        // RULE7
			next_upper  = rd_word[31:16];                       // RULE8
			if (next_latch_toggle != nx_old && rd_idx + IDX_W'(1) < fill) begin
				next_rd_idx = rd_idx + IDX_W'(1);               // RULE9
				next_nx_ack = ~next_latch_ack;                  // RULE9
			end
		end else begin
			next_ro_ack = 1'b0;
		end
		// dropping every arm bit throws the captures away
		if (!latch_enable) begin                                // RULE10
			next_fill   = '0;
			next_rd_idx = '0;
			next_valid  = 1'b0;                                 // RULE21
			next_ro_ack = 1'b0;                                 // RULE21
			next_nx_ack = next_latch_ack;                       // no ack for a discarded entry
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			for (int i = 0; i < LATCH_DEPTH; i++) begin
				store[i] <= '0;
			end
			fill               <= '0;
			rd_idx             <= '0;
			latch_valid_flag   <= 1'b0;
			latch_readout_ack  <= 1'b0;
			next_latch_ack     <= 1'b0;
			nx_old             <= 1'b0;
			input_process_word <= '0;
			latch_upper_word   <= '0;
		end else begin
			store              <= next_store;
			fill               <= next_fill;
			rd_idx             <= next_rd_idx;
			latch_valid_flag   <= next_valid;
			latch_readout_ack  <= next_ro_ack;
			next_latch_ack     <= next_nx_ack;
			nx_old             <= next_latch_toggle;
			input_process_word <= next_pword;
			latch_upper_word   <= next_upper;
		end
	end

	// ------------------------------------------------------------
	// configuration, temperature and hardware faults
	// ------------------------------------------------------------
	logic       param_zero, next_cfg, next_warn, next_ot, next_gen, next_led, supply_old;
	logic [5:0] faults, flags, next_flags;                   // ot, uv, ola, olb, oca, ocb
	logic       next_lost;
	logic [6:0] next_ustep;
	logic [31:0] flash_cnt, next_flash_cnt;

	always_comb begin
		param_zero = 1'b0;
		for (int i = 0; i < PARAM_CNT; i++) begin
			param_zero = param_zero | (motion_params[i*PARAM_W +: PARAM_W] == 16'h0000);
		end
	end
	assign faults = {overcurrent_b_det, overcurrent_a_det, open_load_b_det, open_load_a_det,
		undervoltage_det, temp_sensor > TEMP_SHUTDOWN};
	assign flags  = {overcurrent_b_flag, overcurrent_a_flag, open_load_b_flag, open_load_a_flag,
		undervoltage_flag, overtemp_flag};

	always_comb begin
		// config error follows its causes and never touches the general error
		next_cfg   = param_zero | bad_configuration | !ustep_ok(microstep_resolution); // RULE12 RULE13
		next_ustep = ustep_ok(microstep_resolution) ? microstep_resolution : microstep_setting; // RULE20
		// hysteresis between the two thresholds
		if (temp_sensor >= TEMP_WARN_SET) begin
			next_warn = 1'b1;                                   // RULE14
		end else if (temp_sensor < TEMP_WARN_CLR) begin
			next_warn = 1'b0;                                   // RULE14
		end else begin
			next_warn = temp_warning_flag;
		end
		// sticky flags; a live cause wins over the acknowledge
		next_flags = flags;
		next_lost  = control_supply_lost_flag;
		next_gen   = general_error_flag;
		if (error_acknowledge) begin                            // RULE17
			next_flags = '0;
			next_lost  = 1'b0;
			next_gen   = 1'b0;
		end
		next_flags = next_flags | faults;                       // RULE15
		next_lost  = next_lost | !control_supply_ok;            // RULE15
		if (faults != 6'h00 || !control_supply_ok) begin
			next_gen = 1'b1;                                    // RULE15
		end
		// led blinks only while the shutdown temperature flag stands
		next_flash_cnt = flash_cnt + 32'h0000_0001;
		next_led       = error_b_led;
		if (!overtemp_flag) begin
			next_flash_cnt = '0;
			next_led       = 1'b0;
		end else if (flash_cnt >= 32'(FLASH_CYC - 1)) begin
			next_flash_cnt = '0;
			next_led       = ~error_b_led;                      // RULE19
		end
	end
	assign next_ot = next_flags[0];

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			config_error_flag        <= 1'b0;
			microstep_setting        <= USTEP_RST;
			temp_warning_flag        <= 1'b0;
			{overcurrent_b_flag, overcurrent_a_flag, open_load_b_flag, open_load_a_flag,
				undervoltage_flag, overtemp_flag} <= '0;
			control_supply_lost_flag <= 1'b0;
			general_error_flag       <= 1'b0;
			motor_power_enable       <= 1'b0;
			housing_temperature      <= '0;
			flash_cnt                <= '0;
			error_b_led              <= 1'b0;
			supply_old               <= 1'b1;
			reinit_pulse             <= 1'b0;
		end else begin
			config_error_flag        <= next_cfg;
			microstep_setting        <= next_ustep;
			temp_warning_flag        <= next_warn;
			{overcurrent_b_flag, overcurrent_a_flag, open_load_b_flag, open_load_a_flag,
				undervoltage_flag, overtemp_flag} <= next_flags;
			control_supply_lost_flag <= next_lost;
			general_error_flag       <= next_gen;
			motor_power_enable       <= !next_gen && !next_ot;  // RULE15 RULE19
			housing_temperature      <= temp_sensor;            // RULE18
			flash_cnt                <= next_flash_cnt;
			error_b_led              <= next_led;
			supply_old               <= control_supply_ok;
			reinit_pulse             <= control_supply_ok && !supply_old; // RULE16
		end
	end

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);

	sequence s_armed_event;
		latch_event && latch_enable && fill < target;
	endsequence
	a_valid_after_fill: assert property (s_armed_event ##0 (fill + IDX_W'(1) == target) |=> latch_valid_flag) // RULE6
		else $error("latch valid not raised after last capture");
	a_enable_drop_clears: assert property (!latch_enable |=> !latch_valid_flag && !latch_readout_ack && fill == '0) // RULE10
		else $error("latches kept after enable dropped");
	a_readout_word: assert property (latch_readout_request && latch_valid_flag && latch_enable
		|=> latch_readout_ack && input_process_word == $past(rd_word[15:0])) // RULE7
		else $error("readout word or ack wrong");
	a_next_toggles: assert property ($changed(next_latch_ack) |-> rd_idx == $past(rd_idx) + IDX_W'(1)) // RULE9
		else $error("ack toggled without advancing");
	a_warn_hyst: assert property (temp_warning_flag && temp_sensor >= TEMP_WARN_CLR |=> temp_warning_flag) // RULE14
		else $error("warning dropped inside hysteresis band");
	a_fault_power: assert property (undervoltage_det |=> general_error_flag && undervoltage_flag && !motor_power_enable) // RULE15
		else $error("fault did not cut power");
	a_ack_clears: assert property (error_acknowledge && faults == 6'h00 && control_supply_ok
		|=> !general_error_flag) // RULE17
		else $error("acknowledge did not clear error");
	a_cfg_zero: assert property (motion_params[PARAM_W-1:0] == 16'h0000 |=> config_error_flag) // RULE12
		else $error("zero parameter not flagged");
	a_cfg_no_general: assert property ($rose(config_error_flag) && $past(faults) == 6'h00
		&& $past(control_supply_ok) && !$past(general_error_flag) |-> !general_error_flag) // RULE13
		else $error("config error raised general error");
	a_ustep_legal: assert property (ustep_ok(microstep_setting)) // RULE20
		else $error("illegal microstep setting held");
endmodule

// ### tb/elf_field_model.sv
// field side model: encoder tracks, zero mark, gate and two contacts
`timescale 1ns/1ns
module elf_field_model
	import elf_pkg::*;
(
	input  wire logic               clk,
	output logic     [PIN_CNT-1:0] pins
);
	logic [1:0] ph; // quadrature phase count
	initial begin
		pins = '0;
		ph   = 2'h0;
	end
	// gray order so only one track moves, held past the pin filter
	task automatic step(input int n);
		for (int i = 0; i < n; i++) begin
			@(negedge clk);
			ph = ph + 2'h1;
			pins[PIN_B:PIN_A] = {ph[1], ph[1] ^ ph[0]};
			repeat (6) @(negedge clk);
		end
	endtask
	// one contact level, held long enough to pass the synchroniser
	task automatic set_pin(input int p, input logic v);
		@(negedge clk);
		pins[p] = v;
		repeat (6) @(negedge clk);
	endtask
endmodule

// ### tb/tb.sv
// self-checking bench for the encoder latch and fault status block
`timescale 1ns/1ns
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_fail++; $display("unexpected at %0t: %h not %h", $time, g, e); end end
module tb
	import elf_pkg::*;
;
	// ----------------------------------------
	// signals, named as the ports they drive
	// ----------------------------------------
	typedef struct {int sel; logic [31:0] val;} elf_note_s; // one expected result
	logic clk = 1'b0, sys_rst = 1'b1, arm_zero_mark_latch = 1'b0, arm_input_one_latch = 1'b0, arm_input_two_latch = 1'b0;
	logic arm_gate_rise_latch = 1'b0, arm_gate_fall_latch = 1'b0, latch_readout_request = 1'b0, next_latch_toggle = 1'b0;
	logic clear_position_request = 1'b0, latch_clears_position_enable = 1'b0, latch_array_enable = 1'b0;
	logic input_one_polarity = 1'b0, input_two_polarity = 1'b0, bad_configuration = 1'b0, error_acknowledge = 1'b0;
	logic [7:0] latch_count_setting = 8'h01, temp_sensor = 8'h19;
	logic [6:0] microstep_resolution = 7'h01, microstep_setting;
	logic [5:0] det = 6'h00; // undervolt, open a, open b, over a, over b, supply loss
	logic [PARAM_CNT*PARAM_W-1:0] motion_params = {PARAM_CNT{16'h0001}};
	logic [PIN_CNT-1:0] pins;
	logic [POS_W-1:0] position;
	logic [15:0] input_process_word, latch_upper_word;
	logic [7:0] housing_temperature, tv[6] = '{8'h4F, 8'h50, 8'h46, 8'h3C, 8'h3B, 8'h7D};
	logic wv[6] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1}; // warning expected per temperature step
	logic latch_valid_flag, latch_readout_ack, next_latch_ack, config_error_flag, temp_warning_flag, overtemp_flag;
	logic undervoltage_flag, open_load_a_flag, open_load_b_flag, overcurrent_a_flag, overcurrent_b_flag;
	logic control_supply_lost_flag, general_error_flag, motor_power_enable, error_b_led, reinit_pulse;
	elf_note_s notes[$]; // results still to be seen
	elf_note_s nt;
	int n_fail = 0, n_compared = 0, cyc = 0, idx;
	elf_encoder_latch_fault #(.LATCH_DEPTH(8), .FLASH_CYC(4)) elf_encoder_latch_fault_i (
		.clk, .sys_rst, .pins, .arm_zero_mark_latch, .arm_input_one_latch, .arm_input_two_latch,
		.arm_gate_rise_latch, .arm_gate_fall_latch, .latch_readout_request, .next_latch_toggle,
		.clear_position_request, .latch_clears_position_enable, .latch_array_enable, .latch_count_setting,
		.input_one_polarity, .input_two_polarity, .motion_params, .bad_configuration, .microstep_resolution,
		.temp_sensor, .undervoltage_det(det[0]), .open_load_a_det(det[1]), .open_load_b_det(det[2]),
		.overcurrent_a_det(det[3]), .overcurrent_b_det(det[4]), .control_supply_ok(~det[5]), .error_acknowledge,
		.position, .input_process_word, .latch_upper_word, .latch_valid_flag, .latch_readout_ack, .next_latch_ack,
		.microstep_setting, .housing_temperature, .config_error_flag, .temp_warning_flag, .overtemp_flag,
		.undervoltage_flag, .open_load_a_flag, .open_load_b_flag, .overcurrent_a_flag, .overcurrent_b_flag,
		.control_supply_lost_flag, .general_error_flag, .motor_power_enable, .error_b_led, .reinit_pulse
	);
	elf_field_model elf_field_model_i (.clk, .pins);
	always #2 clk = ~clk;
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	// observed value by selector; magnitudes hide the counting direction
	function automatic logic [31:0] pick(input int s);
		logic [31:0] l, o[14];
		l = {latch_upper_word, input_process_word};
		o = '{position[31] ? -position : position, l[31] ? -l : l, 32'(latch_valid_flag), 32'(latch_readout_ack),
			32'(next_latch_ack), 32'(config_error_flag), 32'(temp_warning_flag), 32'(general_error_flag),
			32'(motor_power_enable), 32'({overtemp_flag, control_supply_lost_flag, overcurrent_b_flag,
			overcurrent_a_flag, open_load_b_flag, open_load_a_flag, undervoltage_flag}), 32'(microstep_setting),
			32'(housing_temperature), 32'(error_b_led), 32'(reinit_pulse)};
		return o[s];
	endfunction
	task automatic want(input int s, input logic [31:0] v);
		notes.push_back('{s, v});
	endtask
	task automatic tick(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic pulse(input int p);
		elf_field_model_i.set_pin(p, 1'b1);
		elf_field_model_i.set_pin(p, 1'b0);
	endtask
	task automatic tgl();
		next_latch_toggle = ~next_latch_toggle;
		tick(3);
	endtask
	task automatic ack_err();
		error_acknowledge = 1'b1;
		tick(1);
		error_acknowledge = 1'b0;
		tick(3);
	endtask
	task automatic test_done();
		if (n_fail == 0 && n_compared > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	// observer: after the driver's notes land, compare oldest first
	always @(negedge clk) begin
		#1;
		while (notes.size() > 0) begin
			nt = notes.pop_front();
			`CHK(pick(nt.sel), nt.val)
		end
	end
	// hang guard, far above the roughly 300 cycles the run needs
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 8000) begin
			n_fail++;
			test_done();
		end
	end
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		void'($urandom(56));
		tick(12);
		sys_rst = 1'b0;
		tick(3);
		want(10, 32'h1);
		want(8, 32'h1);
		elf_field_model_i.step(5);
		want(0, 32'h5);
		arm_zero_mark_latch = 1'b1;
		pulse(PIN_ZERO);
		want(2, 32'h1);
		latch_readout_request = 1'b1;
		tick(2);
		want(3, 32'h1);
		want(1, 32'h5);
		tgl();
		want(4, 32'h0);
		arm_zero_mark_latch = 1'b0;
		tick(2);
		want(2, 32'h0);
		want(3, 32'h0);
		latch_array_enable = 1'b1;
		latch_count_setting = 8'h03;
		arm_input_one_latch = 1'b1;
		pulse(PIN_IN1);
		pulse(PIN_IN1);
		want(2, 32'h0);
		elf_field_model_i.step(2);
		pulse(PIN_IN1);
		want(2, 32'h1);
		want(1, 32'h5);
		tgl();
		want(4, 32'h1);
		tgl();
		want(4, 32'h0);
		want(1, 32'h7);
		tgl();
		want(4, 32'h0);
		arm_input_one_latch = 1'b0;
		latch_array_enable = 1'b0;
		latch_clears_position_enable = 1'b1;
		tick(1);
		arm_gate_rise_latch = 1'b1;
		tick(1);
		clear_position_request = 1'b1;
		pulse(PIN_GATE);
		want(0, 32'h0);
		want(1, 32'h7);
		arm_gate_rise_latch = 1'b0;
		input_two_polarity = 1'b1;
		tick(8);
		arm_input_two_latch = 1'b1;
		elf_field_model_i.set_pin(PIN_IN2, 1'b1);
		want(2, 32'h0);
		elf_field_model_i.set_pin(PIN_IN2, 1'b0);
		want(2, 32'h1);
		arm_input_two_latch = 1'b0;
		tick(1);
		arm_gate_fall_latch = 1'b1;
		elf_field_model_i.set_pin(PIN_GATE, 1'b1);
		want(2, 32'h0);
		elf_field_model_i.set_pin(PIN_GATE, 1'b0);
		want(2, 32'h1);
		idx = 0;
		repeat (2) begin
			motion_params[idx*PARAM_W +: PARAM_W] = 16'h0000;
			tick(3);
			want(5, 32'h1);
			want(7, 32'h0);
			motion_params[idx*PARAM_W +: PARAM_W] = 16'($urandom_range(16'hFFFF, 1));
			idx = $urandom_range(PARAM_CNT - 1);
		end
		bad_configuration = 1'b1;
		tick(3);
		want(5, 32'h1);
		bad_configuration = 1'b0;
		for (int k = 0; k < 7; k++) begin
			microstep_resolution = 7'h01 << k;
			tick(3);
			want(10, 32'(7'h01 << k));
			want(5, 32'h0);
		end
		microstep_resolution = 7'h03;
		tick(3);
		want(10, 32'h40);
		want(5, 32'h1);
		foreach (tv[i]) begin
			temp_sensor = tv[i];
			tick(3);
			want(6, 32'(wv[i]));
			want(11, 32'(tv[i]));
		end
		want(9, 32'h0);
		temp_sensor = 8'h7E;
		tick(3);
		want(9, 32'h40);
		want(8, 32'h0);
		tick(2);
		want(12, 32'h1);
		tick(4);
		want(12, 32'h0);
		ack_err();
		want(7, 32'h1);
		temp_sensor = 8'h19;
		ack_err();
		want(7, 32'h0);
		want(12, 32'h0);
		for (int i = 0; i < 6; i++) begin
			det[i] = 1'b1;
			tick(3);
			want(9, 32'h1 << i);
			want(7, 32'h1);
			want(8, 32'h0);
			det[i] = 1'b0;
			tick(1);
			want(13, 32'(i == 5));
			ack_err();
			want(7, 32'h0);
		end
		tick(2);
		test_done();
	end
endmodule
